// File: src/fph_flash_dev.sv
// Purpose: flash front end: ultra sleep entry and exit, pause, soft reset
// Assumes: SPI mode 0, all link pins sampled by two flops at 100 MHz
// Notes:   other commands are passed out as bytes on rx_byte/rx_valid
// Operation
// - ultra sleep ignores every command
// - 79h then select release enters ultra sleep
// - bits after 79h are discarded
// - partial 79h leaves device in standby
// - no ultra sleep while program busy
// - power up lands in standby
// - select toggle exits, dummy byte ignored
// - reselect before exit time drops command
// - early first bit wakes but drops command
// - power cycle restores all defaults
// - pause never stops program or erase
// - pause only with select, sck low
// - pause during sck high waits low
// - paused: output off, sck and si ignored
// - pause ends in sck low or on select release
// - release while paused aborts, clears latch
// - soft reset needs reset enable bit
// - F0h then D0h, later bytes ignored
// - soft reset ignores write enable latch
// - soft reset keeps enable bit, clears latch
// - partial or unaligned reset is ignored
// - soft reset returns engine to idle
`timescale 1ns/1ns
module fph_flash_dev
  import fph_pkg::*;
(
  input  wire logic   clock,
  input  wire logic   rst,
  fph_link_if.dev     link,
  input  wire logic   prog_busy,
  input  wire logic   op_done,
  input  wire logic   so_data,
  input  wire logic   so_en,
  output logic [7:0]  rx_byte,
  output logic        rx_valid,
  output logic        rx_first,
  output logic        write_enable_latch,
  output logic        reset_enable_bit,
  output logic        ultra_sleep,
  output logic        standby,
  output logic        paused,
  output logic        op_abort,
  output logic        wp_active
);

  typedef struct packed {
    logic [1:0] cs_s;
    logic [1:0] sck_s;
    logic [1:0] si_s;
    logic [1:0] hold_s;
    logic [1:0] wp_s;
    logic       cs_p;
    logic       sck_p;
    fph_mode_t  mode;
    fph_tmr_t   tmr;
    logic       drop;
    logic       paused;
    logic       conf_ok;
    logic [2:0] bit_cnt;
    logic [1:0] byte_cnt;
    logic [7:0] shift;
    logic [7:0] opcode;
    logic       latch;
    logic       rst_en;
    logic       abort;
    logic       rx_valid;
    logic       rx_first;
    logic       so;
  } fph_dev_state_t;

  fph_dev_state_t q;
  fph_dev_state_t d;

  logic       cs_lo;
  logic       cs_fall;
  logic       cs_rise;
  logic       sck_rise;
  logic       hold_on;
  logic [7:0] next_byte;

  // decoded link events, all from the second sync flop onward
  assign cs_lo     = !q.cs_s[1];
  assign cs_fall   = !q.cs_s[1] && q.cs_p;
  assign cs_rise   = q.cs_s[1] && !q.cs_p;
  assign sck_rise  = q.sck_s[1] && !q.sck_p;
  assign hold_on   = !q.hold_s[1];
  assign next_byte = {q.shift[6:0], q.si_s[1]};

  // next state
  always_comb begin
    d          = q;
    d.abort    = 1'b0;
    d.rx_valid = 1'b0;
    d.cs_s     = {q.cs_s[0], link.cs_n};
    d.sck_s    = {q.sck_s[0], link.sck};
    d.si_s     = {q.si_s[0], link.si};
    d.hold_s   = {q.hold_s[0], link.hold_n};
    d.wp_s     = {q.wp_s[0], link.wp_n};
    d.cs_p     = q.cs_s[1];
    d.sck_p    = q.sck_s[1];
    d.so       = so_data;
    d.tmr      = fph_dec(q.tmr);

    // engine finished; pause has no say over it
    // engine runs on
    if (op_done) begin
      d.latch = 1'b0;
    end

    // pause follows hold only while sck is low
    // select gated pause
    if (!cs_lo) begin
      d.paused = 1'b0;
    end else if (!q.sck_s[1]) begin
      d.paused = hold_on;
    end

    // power mode sequencing
    unique case (q.mode)
      FPH_STANDBY: begin
      end
      FPH_ENTERING: begin
        if (q.tmr == '0) begin
          d.mode = FPH_SLEEP;
        end
      end
      FPH_SLEEP: begin
        if (cs_fall) begin
          d.mode = FPH_WAKING;
          d.tmr  = EXIT_CYC_DEV;
        end
      end
      FPH_WAKING: begin
        if (cs_rise) begin
          d.tmr = EXIT_CYC_DEV;
        end else if (q.tmr == '0) begin
          d.mode = FPH_STANDBY;
        end
      end
    endcase

    // frame start; a reselect while not ready loses the frame
    if (cs_fall) begin
      d.bit_cnt  = '0;
      d.byte_cnt = '0;
      d.conf_ok  = 1'b0;
      d.opcode   = OP_NONE;
      d.drop     = (q.mode == FPH_WAKING) || (q.mode == FPH_ENTERING);
    end

    // shifting; sck is ignored while paused
    // inputs ignored
    if (cs_lo && sck_rise && !q.paused) begin
      if (q.mode == FPH_WAKING) begin
        d.drop = 1'b1;
      end else if (q.mode == FPH_STANDBY && !q.drop) begin
        d.shift   = next_byte;
        d.bit_cnt = q.bit_cnt + 3'd1;
        if (q.bit_cnt == 3'd7) begin
          d.rx_valid = 1'b1;
          d.rx_first = (q.byte_cnt == 2'd0);
          // saturate so trailing bytes cannot alias the first two
          if (q.byte_cnt != 2'd3) begin
            d.byte_cnt = q.byte_cnt + 2'd1;
          end
          if (q.byte_cnt == 2'd0) begin
            d.opcode = next_byte;
          end else if (q.byte_cnt == 2'd1) begin
            d.conf_ok = (q.opcode == OP_SOFT_RESET) && (next_byte == OP_RESET_CONFIRM);
            if (q.opcode == OP_STATUS2_WRITE) begin
              d.rst_en = next_byte[RST_EN_BIT];
            end
          end
        end
      end
    end

    // frame end actions
    if (cs_rise) begin
      d.drop = 1'b0;
      if (hold_on) begin
        d.abort = 1'b1;
        d.latch = 1'b0;
      end else if (q.mode == FPH_STANDBY && !q.drop) begin
        if (q.opcode == OP_ULTRA_SLEEP && q.byte_cnt != 2'h0 && !prog_busy) begin
          d.mode = FPH_ENTERING;
          d.tmr  = ENTRY_CYC_DEV;
        end else if (q.opcode == OP_SOFT_RESET && q.conf_ok && q.bit_cnt == 3'h0 &&
                     q.rst_en) begin
          d.abort = 1'b1;
          d.latch = LATCH_RESET;
        end else if (q.opcode == OP_WRITE_ENABLE && q.byte_cnt == 2'h1 &&
                     q.bit_cnt == 3'h0) begin
          d.latch = 1'b1;
        end
      end
    end
  end

  // state register; reset stands for a power cycle
  // standby defaults
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      q          <= '0;
      q.cs_s     <= 2'h3;
      q.cs_p     <= 1'b1;
      q.hold_s   <= 2'h3;
      q.wp_s     <= 2'h3;
      q.mode     <= FPH_STANDBY;
      q.opcode   <= OP_NONE;
      q.latch    <= LATCH_RESET;
      q.rst_en   <= RST_EN_RESET;
    end else begin
      q <= d;
    end
  end

  // output is released whenever paused, asleep or dropping
  // output off
  assign link.so_oe = cs_lo && !q.paused && q.mode == FPH_STANDBY && !q.drop && so_en;
  assign link.so    = q.so;

  assign rx_byte            = q.shift;
  assign rx_valid           = q.rx_valid;
  assign rx_first           = q.rx_first;
  assign write_enable_latch = q.latch;
  assign reset_enable_bit   = q.rst_en;
  assign ultra_sleep        = (q.mode == FPH_SLEEP);
  assign standby            = (q.mode == FPH_STANDBY);
  assign paused             = q.paused;
  assign op_abort           = q.abort;
  // protect pin stays live through a pause
  assign wp_active          = !q.wp_s[1];

endmodule : fph_flash_dev

// File: src/fph_pkg.sv
// Purpose: shared constants and types for the power, pause and reset front end
// Assumes: 100 MHz system clock on both ends, SPI mode 0 framing
// Notes:   times are given in ns and turned into cycle counts here
package fph_pkg;

  // command and confirmation codes
  localparam logic [7:0] OP_ULTRA_SLEEP   = 8'h79;
  localparam logic [7:0] OP_STATUS2_WRITE = 8'h31;
  localparam logic [7:0] OP_SOFT_RESET    = 8'hf0;
  localparam logic [7:0] OP_RESET_CONFIRM = 8'hd0;
  localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
  localparam logic [7:0] OP_NONE          = 8'h00;

  // position of the reset enable bit in status byte 2
  localparam int RST_EN_BIT = 4;

  // reset values of the status bits
  localparam logic LATCH_RESET  = 1'b0;
  localparam logic RST_EN_RESET = 1'b0;

  // times in ns
  localparam int CLK_PERIOD_NS  = 10;
  localparam int ENTRY_TIME_NS  = 3000;
  localparam int EXIT_TIME_NS   = 30000;
  localparam int SEL_LOW_MIN_NS = 20000;
  localparam int CS_HIGH_MIN_NS = 25;
  localparam int SCK_HALF_NS    = 80;

  typedef logic [11:0] fph_tmr_t;

  // device side: longest times round down
  localparam fph_tmr_t ENTRY_CYC_DEV = fph_tmr_t'(ENTRY_TIME_NS / CLK_PERIOD_NS);
  localparam fph_tmr_t EXIT_CYC_DEV  = fph_tmr_t'(EXIT_TIME_NS / CLK_PERIOD_NS);
  // host side: least times round up
  localparam fph_tmr_t EXIT_CYC_HOST =
    fph_tmr_t'((EXIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam fph_tmr_t SEL_LOW_CYC_HOST =
    fph_tmr_t'((SEL_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam fph_tmr_t CS_HIGH_CYC_HOST =
    fph_tmr_t'((CS_HIGH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // timer counts down to zero, so one less than the half period
  localparam fph_tmr_t SCK_HALF_CYC = fph_tmr_t'(SCK_HALF_NS / CLK_PERIOD_NS - 1);

  typedef enum logic [1:0] {
    FPH_STANDBY,
    FPH_ENTERING,
    FPH_SLEEP,
    FPH_WAKING
  } fph_mode_t;

  typedef enum logic [2:0] {
    FPH_H_IDLE,
    FPH_H_LEAD,
    FPH_H_LOW,
    FPH_H_HIGH,
    FPH_H_TAIL,
    FPH_H_GAP
  } fph_host_st_t;

  // saturating down count shared by both ends
  function automatic fph_tmr_t fph_dec(input fph_tmr_t t);
    fph_dec = (t == '0) ? '0 : fph_tmr_t'(t - 12'h001);
  endfunction : fph_dec

endpackage : fph_pkg

// File: src/fph_link_if.sv
// Purpose: serial link between host controller and flash front end
// Assumes: the bench resolves the data out wire from so_oe
// Notes:   no clocking block; both ends sample on their own clock
`timescale 1ns/1ns
interface fph_link_if;
  logic cs_n;
  logic sck;
  logic si;
  logic so;
  logic so_oe;
  logic hold_n;
  logic wp_n;

  modport dev (
    input  cs_n,
    input  sck,
    input  si,
    input  hold_n,
    input  wp_n,
    output so,
    output so_oe
  );

  modport host (
    output cs_n,
    output sck,
    output si,
    output hold_n,
    output wp_n,
    input  so,
    input  so_oe
  );
endinterface : fph_link_if

// File: src/fph_flash_host.sv
// Purpose: host end: frames of up to two bytes, pause and wake timing
// Assumes: sck made here by dividing the 100 MHz clock, 160 ns period
// Notes:   frames with zero bytes are plain select pulses for waking
`timescale 1ns/1ns
module fph_flash_host
  import fph_pkg::*;
(
  input  wire logic   clock,
  input  wire logic   rst,
  fph_link_if.host    link,
  input  wire logic   start,
  input  wire logic [1:0] nbytes,
  input  wire logic [7:0] byte0,
  input  wire logic [7:0] byte1,
  input  wire logic   pre_wait,
  input  wire logic   pause_req,
  input  wire logic   protect,
  output logic        busy,
  output logic        done
);

  typedef struct packed {
    fph_host_st_t st;
    fph_tmr_t     tmr;
    logic [15:0]  shift;
    logic [4:0]   left;
    logic         cs_n;
    logic         sck;
    logic         si;
    logic         hold_n;
    logic         done;
  } fph_host_state_t;

  fph_host_state_t q;
  fph_host_state_t d;

  // next state
  always_comb begin
    d      = q;
    d.done = 1'b0;
    d.tmr  = fph_dec(q.tmr);

    // pause only with select, sck low
    if (!q.sck) begin
      d.hold_n = q.cs_n || !pause_req;
    end

    unique case (q.st)
      FPH_H_IDLE: begin
        if (start) begin
          d.st    = FPH_H_LEAD;
          d.cs_n  = 1'b0;
          d.shift = (nbytes == 2'd1) ? {byte0, 8'h00} : {byte0, byte1};
          d.left  = (nbytes == 2'd0) ? 5'd0 : ((nbytes == 2'd1) ? 5'd8 : 5'd16);
          if (nbytes == 2'd0) begin
            d.tmr = SEL_LOW_CYC_HOST;
          end else if (pre_wait) begin
            d.tmr = EXIT_CYC_HOST;
          end else begin
            d.tmr = SCK_HALF_CYC;
          end
        end
      end
      FPH_H_LEAD: begin
        if (q.tmr == '0) begin
          d.st  = (q.left == 5'd0) ? FPH_H_TAIL : FPH_H_LOW;
          d.si  = q.shift[15];
          d.tmr = SCK_HALF_CYC;
        end
      end
      // clock stays low while paused
      FPH_H_LOW: begin
        // no rise on the edge that starts a pause, or both pins move at once
        if (q.tmr == '0 && q.hold_n && d.hold_n) begin
          d.sck = 1'b1;
          d.st  = FPH_H_HIGH;
          d.tmr = SCK_HALF_CYC;
        end
      end
      FPH_H_HIGH: begin
        if (q.tmr == '0) begin
          d.sck   = 1'b0;
          d.shift = {q.shift[14:0], 1'b0};
          d.si    = q.shift[14];
          d.left  = q.left - 5'd1;
          d.tmr   = SCK_HALF_CYC;
          d.st    = (q.left == 5'd1) ? FPH_H_TAIL : FPH_H_LOW;
        end
      end
      // release waits while the pause pin moves; a pause still held here
      // releases select under it, which aborts the frame on purpose
      FPH_H_TAIL: begin
        if (q.tmr == '0 && (q.hold_n == d.hold_n)) begin
          d.cs_n = 1'b1;
          d.st   = FPH_H_GAP;
          d.tmr  = CS_HIGH_CYC_HOST;
        end
      end
      FPH_H_GAP: begin
        if (q.tmr == '0) begin
          d.st   = FPH_H_IDLE;
          d.done = 1'b1;
        end
      end
      default: begin
        d.st = FPH_H_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      q        <= '0;
      q.st     <= FPH_H_IDLE;
      q.cs_n   <= 1'b1;
      q.hold_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign link.cs_n   = q.cs_n;
  assign link.sck    = q.sck;
  assign link.si     = q.si;
  assign link.hold_n = q.hold_n;
  assign link.wp_n   = !protect;
  assign busy        = (q.st != FPH_H_IDLE);
  assign done        = q.done;

endmodule : fph_flash_host

// File: testbench/fph_link_sva.sv
// Purpose: link checks between the host end and the flash end
// Assumes: both ends run on one 100 MHz clock
// Notes:   sees link pins only; mode level behaviour is judged in the bench
`timescale 1ns/1ns
module fph_link_sva (
  input wire logic clock,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic so,
  input wire logic so_oe,
  input wire logic hold_n,
  input wire logic wp_n
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (rst);

  // pause may start only while selected and in a clock low phase
  property p_hold_fall;
    $fell(hold_n) |-> !cs_n && !sck;
  endproperty
  a_hold_fall: assert property (p_hold_fall) else $error("pause began outside low phase");

  // clock frozen low while paused
  property p_hold_freeze;
    !hold_n |-> !sck;
  endproperty
  a_hold_freeze: assert property (p_hold_freeze) else $error("clock moved while paused");

  // output released once the pause has settled through the sync flops
  property p_hold_quiet;
    (!hold_n && !cs_n) [*5] |-> !so_oe;
  endproperty
  a_hold_quiet: assert property (p_hold_quiet) else $error("data out driven while paused");

  // serial clock stands still outside frames
  property p_sck_idle;
    cs_n |-> !sck;
  endproperty
  a_sck_idle: assert property (p_sck_idle) else $error("clock ran while deselected");

  // data in stable across every high phase
  property p_si_hold;
    sck |-> $stable(si);
  endproperty
  a_si_hold: assert property (p_si_hold) else $error("data in moved while clock high");

  // high phase lasts exactly eight system clocks
  property p_sck_high;
    $rose(sck) |-> sck [*8] ##1 !sck;
  endproperty
  a_sck_high: assert property (p_sck_high) else $error("clock high phase not eight cycles");

  // select high time between frames
  property p_cs_gap;
    $rose(cs_n) |-> cs_n [*3];
  endproperty
  a_cs_gap: assert property (p_cs_gap) else $error("select high gap too short");

  // deselected device leaves data out undriven
  property p_idle_quiet;
    cs_n [*4] |-> !so_oe;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("data out driven while idle");

  c_pause: cover property ($fell(hold_n));
  c_frame: cover property ($rose(cs_n));
  c_drive: cover property (so_oe && so);
  c_protect: cover property ($fell(wp_n));
endmodule : fph_link_sva

// File: testbench/test_flash_power_hold_reset_ctrl.sv
// Purpose: host end and flash end joined on one link, one task per behaviour
// Assumes: inputs change on the falling clock edge
// Notes:   waits derive from package cycle counts plus sync slack
`timescale 1ns/1ns
module test_flash_power_hold_reset_ctrl
  import fph_pkg::*;
;
  logic       clock, rst, prog_busy, op_done, so_en, start, pre_wait, pause_req;
  logic       protect, busy, done, abort_seen, abort_clr, rx_valid, rx_first;
  logic [1:0] nbytes;
  logic [7:0] byte0, byte1, rx_byte;
  logic       write_enable_latch, reset_enable_bit, ultra_sleep, standby;
  logic       paused, op_abort, wp_active;
  int         bad_count, n_tests, rx_count;

  fph_link_if fph_link_if_i ();
  fph_flash_dev fph_flash_dev_i (.clock(clock), .rst(rst), .link(fph_link_if_i.dev),
    .prog_busy(prog_busy), .op_done(op_done), .so_data(1'b1), .so_en(so_en),
    .rx_byte(rx_byte), .rx_valid(rx_valid), .rx_first(rx_first),
    .write_enable_latch(write_enable_latch),
    .reset_enable_bit(reset_enable_bit), .ultra_sleep(ultra_sleep), .standby(standby),
    .paused(paused), .op_abort(op_abort), .wp_active(wp_active));
  fph_flash_host fph_flash_host_i (.clock(clock), .rst(rst), .link(fph_link_if_i.host),
    .start(start), .nbytes(nbytes), .byte0(byte0), .byte1(byte1), .pre_wait(pre_wait),
    .pause_req(pause_req), .protect(protect), .busy(busy), .done(done));
  fph_link_sva fph_link_sva_i (.clock(clock), .rst(rst), .cs_n(fph_link_if_i.cs_n),
    .sck(fph_link_if_i.sck), .si(fph_link_if_i.si), .so(fph_link_if_i.so),
    .so_oe(fph_link_if_i.so_oe), .hold_n(fph_link_if_i.hold_n), .wp_n(fph_link_if_i.wp_n));

  // free running system clock
  always #5 clock = ~clock;

  // abort pulse is one cycle, so latch it; byte pulses are counted
  always @(posedge clock) begin
    if (rst) begin
      abort_seen <= 1'b0;
      rx_count   <= 0;
    end else begin
      if (abort_clr) begin
        abort_seen <= 1'b0;
      end else if (op_abort === 1'b1) begin
        abort_seen <= 1'b1;
      end
      if (rx_valid === 1'b1) begin
        rx_count <= rx_count + 1;
      end
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic idle(input int n);
    repeat (n) @(negedge clock);
  endtask : idle

  // one host frame; bounded wait on done, longest frame is a pre-wait wake
  task automatic send(input logic [1:0] nb, input logic [7:0] b0, input logic [7:0] b1,
                      input logic pw);
    int k;
    @(negedge clock);
    nbytes = nb;
    byte0 = b0;
    byte1 = b1;
    pre_wait = pw;
    start = 1'b1;
    @(negedge clock);
    start = 1'b0;
    chk(busy, 1'b1);
    k = 0;
    while (done !== 1'b1 && k < 8000) begin
      @(negedge clock);
      k++;
    end
    chk(done, 1'b1);
    chk(busy, 1'b0);
  endtask : send

  task automatic clr_latch;
    op_done = 1'b1;
    idle(1);
    op_done = 1'b0;
    idle(1);
  endtask : clr_latch

  task automatic clr_abort;
    abort_clr = 1'b1;
    idle(1);
    abort_clr = 1'b0;
  endtask : clr_abort

  // opcode then release enters sleep, trailing byte dropped
  task automatic enter(input logic [1:0] nb);
    send(nb, OP_ULTRA_SLEEP, OP_WRITE_ENABLE, 1'b0);
    idle(int'(ENTRY_CYC_DEV) + 10);
    chk(ultra_sleep, 1'b1);
    chk(write_enable_latch, 1'b0);
  endtask : enter

  // power up state, reset refused while disabled
  task automatic t_locked;
    int r0;
    chk(standby, 1'b1);
    chk(reset_enable_bit, 1'b0);
    r0 = rx_count;
    send(2'd1, OP_WRITE_ENABLE, OP_NONE, 1'b0);
    chk(write_enable_latch, 1'b1);
    chk(rx_byte, OP_WRITE_ENABLE);
    chk(rx_first, 1'b1);
    chk(8'(rx_count - r0), 8'h01);
    clr_abort();
    send(2'd2, OP_SOFT_RESET, OP_RESET_CONFIRM, 1'b0);
    idle(4);
    chk(abort_seen, 1'b0);
    chk(rx_byte, OP_RESET_CONFIRM);
    chk(rx_first, 1'b0);
    chk(write_enable_latch, 1'b1);
  endtask : t_locked

  // soft reset once enabled, with broken forms refused
  task automatic t_reset;
    prog_busy = 1'b1;
    send(2'd2, OP_STATUS2_WRITE, 8'(1 << RST_EN_BIT), 1'b0);
    chk(reset_enable_bit, 1'b1);
    send(2'd2, OP_SOFT_RESET, OP_NONE, 1'b0);
    send(2'd1, OP_SOFT_RESET, OP_NONE, 1'b0);
    idle(4);
    chk(abort_seen, 1'b0);
    send(2'd2, OP_SOFT_RESET, OP_RESET_CONFIRM, 1'b0);
    idle(4);
    chk(abort_seen, 1'b1);
    chk(write_enable_latch, 1'b0);
    chk(reset_enable_bit, 1'b1);
    chk(standby, 1'b1);
    clr_abort();
    send(2'd2, OP_SOFT_RESET, OP_RESET_CONFIRM, 1'b0);
    idle(4);
    chk(abort_seen, 1'b1);
  endtask : t_reset

  // no sleep while busy, then toggle exit with early reselect
  task automatic t_toggle;
    int r0;
    send(2'd1, OP_ULTRA_SLEEP, OP_NONE, 1'b0);
    idle(int'(ENTRY_CYC_DEV) + 10);
    chk(ultra_sleep, 1'b0);
    prog_busy = 1'b0;
    enter(2'd2);
    send(2'd0, OP_NONE, OP_NONE, 1'b0);
    chk(standby, 1'b0);
    chk(ultra_sleep, 1'b0);
    r0 = rx_count;
    send(2'd2, OP_STATUS2_WRITE, OP_NONE, 1'b0);
    chk(8'(rx_count - r0), 8'h00);
    idle(int'(EXIT_CYC_DEV) + 10);
    chk(standby, 1'b1);
    chk(reset_enable_bit, 1'b1);
  endtask : t_toggle

  // early first bit wakes but is dropped; waited bit is taken
  task automatic t_low_exit;
    int r0;
    enter(2'd1);
    r0 = rx_count;
    send(2'd1, OP_WRITE_ENABLE, OP_NONE, 1'b0);
    chk(write_enable_latch, 1'b0);
    chk(8'(rx_count - r0), 8'h00);
    idle(int'(EXIT_CYC_DEV) + 10);
    chk(standby, 1'b1);
    enter(2'd1);
    send(2'd1, OP_WRITE_ENABLE, OP_NONE, 1'b1);
    chk(write_enable_latch, 1'b1);
    chk(standby, 1'b1);
  endtask : t_low_exit

  // pause mid frame, protect still seen, frame resumes
  task automatic t_pause;
    clr_latch();
    so_en = 1'b1;
    fork
      send(2'd1, OP_WRITE_ENABLE, OP_NONE, 1'b0);
      begin
        idle(40);
        chk(fph_link_if_i.so_oe, 1'b1);
        chk(fph_link_if_i.so, 1'b1);
        pause_req = 1'b1;
        idle(30);
        chk(paused, 1'b1);
        chk(fph_link_if_i.so_oe, 1'b0);
        protect = 1'b1;
        idle(6);
        chk(wp_active, 1'b1);
        pause_req = 1'b0;
        protect = 1'b0;
        idle(30);
        chk(paused, 1'b0);
      end
    join
    so_en = 1'b0;
    chk(write_enable_latch, 1'b1);
  endtask : t_pause

  // select released with pause still held aborts and clears the latch
  task automatic t_abort;
    clr_abort();
    chk(write_enable_latch, 1'b1);
    pause_req = 1'b1;
    send(2'd0, OP_NONE, OP_NONE, 1'b0);
    pause_req = 1'b0;
    idle(4);
    chk(abort_seen, 1'b1);
    chk(write_enable_latch, 1'b0);
    chk(standby, 1'b1);
  endtask : t_abort

  // reset while asleep brings back power-on defaults
  task automatic t_power_cycle;
    clr_latch();
    enter(2'd1);
    rst = 1'b1;
    idle(4);
    rst = 1'b0;
    idle(4);
    chk(standby, 1'b1);
    chk(ultra_sleep, 1'b0);
    chk(reset_enable_bit, 1'b0);
  endtask : t_power_cycle

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : close_out

  // main sequence
  initial begin
    {clock, prog_busy, op_done, so_en, start, pre_wait, pause_req, protect} = '0;
    {nbytes, byte0, byte1, abort_clr} = '0;
    rst = 1'b1;
    idle(4);
    rst = 1'b0;
    idle(2);
    t_locked();
    t_reset();
    t_toggle();
    t_low_exit();
    t_pause();
    t_abort();
    t_power_cycle();
    close_out();
  end

  // hang guard, well above the roughly 20k cycles the run needs
  initial begin
    repeat (60000) @(posedge clock);
    bad_count++;
    close_out();
  end
endmodule : test_flash_power_hold_reset_ctrl
